// ==== src/sgp_defs.svh ====
// register offsets, field positions, flash command bytes and bus-cycle timing
// assumes byte-mode flash wiring: flash address bit 0 is the byte-select line below A0
`ifndef SGP_DEFS_SVH
`define SGP_DEFS_SVH

// own register map, one aligned word each
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0c
`define REG_MODE        8'h10
`define REG_PROT        8'h14

// field positions
`define CTRL_START_BIT  8
`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_ERR_BIT      2
`define MODE_VID_BIT    0
`define MODE_WPN_BIT    1
`define MODE_TOP_BIT    2
`define MODE_RSTN_BIT   3

// reset values
`define MODE_RESET      4'ha
`define PROT_RESET      9'h000

// command cycle addresses and data (byte mode)
`define SEQ_ADDR_1      20'h00aaa
`define SEQ_ADDR_2      20'h00555
`define SEQ_ADDR_0      20'h00000
`define SEQ_DATA_1      8'haa
`define SEQ_DATA_2      8'h55
`define CMD_PROG_BYTE   8'ha0
`define CMD_ENTER_BYTE  8'h88
`define CMD_EXIT_BYTE   8'h90
`define CMD_EXIT2_BYTE  8'h00
`define CMD_RESET_BYTE  8'hf0
`define CMD_PROT_BYTE   8'h60

// low address byte A7..A0 for protect, unprotect, secure group
`define PROT_LOW        8'h02
`define UNPROT_LOW      8'h42
`define SEC_GROUP_LOW   8'h1a

// bus cycle timing, ns, and derived cycle counts at the clock period
`define CLK_NS          10
`define SETUP_NS        20
`define PULSE_NS        50
`define HOLD_NS         20
`define SETUP_CYC       ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_CYC       ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC        ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== src/sgp_pkg.sv ====
// types shared by the protection host controller and its bus-cycle engine
// assumes sgp_defs.svh supplies every number
package sgp_pkg;

  typedef enum logic [3:0] {
    CMD_READ      = 4'h0,
    CMD_WRITE     = 4'h1,
    CMD_PROGRAM   = 4'h2,
    CMD_SEC_ENTER = 4'h3,
    CMD_SEC_EXIT  = 4'h4,
    CMD_RESET     = 4'h5,
    CMD_PROTECT   = 4'h6,
    CMD_UNPROTECT = 4'h7,
    CMD_LOCK_SEC  = 4'h8
  } cmd_t;

  typedef struct packed {
    logic        we;
    logic [19:0] addr;
    logic [7:0]  data;
    logic        last;
  } step_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b01,
    CS_RUN  = 2'b10
  } ctl_state_t;

  typedef enum logic [3:0] {
    ES_IDLE  = 4'b0001,
    ES_SETUP = 4'b0010,
    ES_PULSE = 4'b0100,
    ES_HOLD  = 4'b1000
  } eng_state_t;

endpackage

// ==== src/flash_cycle_if.sv ====
// request and answer between the sequencer and the flash bus-cycle engine
// assumes both ends on aclk; req holds until ack pulses
`timescale 1ns/1ps
interface flash_cycle_if;
  logic        req;
  logic        we;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;

  modport ctrl   (output req, output we, output addr, output wdata, input ack, input rdata);
  modport engine (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// ==== src/flash_cycle.sv ====
// one asynchronous flash read or write cycle: setup, strobe pulse, hold
// assumes the data pin is resolved outside from dq_o and dq_oe
`timescale 1ns/1ps
`include "sgp_defs.svh"
module flash_cycle (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // sequencer side
  flash_cycle_if.engine     cyc,
  // flash pins
  output logic [19:0]       addr_o,
  input  wire logic [7:0]   dq_i,
  output logic [7:0]        dq_o,
  output logic              dq_oe,
  output logic              ce_n,
  output logic              oe_n,
  output logic              we_n
);
  import sgp_pkg::*;

  eng_state_t  st_r,   st_nxt;
  logic [7:0]  cnt_r,  cnt_nxt;
  logic        we_r,   we_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [7:0]  dout_r, dout_nxt;
  logic [7:0]  rd_r,   rd_nxt;
  logic [7:0]  s1_r, s2_r, s3_r;

  // read data passes three stages; the value counts once stages two and three agree
  always_ff @(posedge aclk)
  begin
    s1_r <= dq_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // cycle sequencing
  always_comb
  begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    we_nxt   = we_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    rd_nxt   = rd_r;
    case (st_r)
      ES_IDLE:
      begin
        if (cyc.req)
        begin
          we_nxt   = cyc.we;
          addr_nxt = cyc.addr;
          dout_nxt = cyc.wdata;
          cnt_nxt  = 8'(`SETUP_CYC);
          st_nxt   = ES_SETUP;
        end
      end
      ES_SETUP:
      begin
        if (cnt_r <= 8'h01)
        begin
          cnt_nxt = 8'(`PULSE_CYC);
          st_nxt  = ES_PULSE;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      ES_PULSE:
      begin
        // an unsettled read bus stretches the pulse rather than sample a mix of bits
        if (cnt_r > 8'h01)
          cnt_nxt = cnt_r - 8'h01;
        else if (we_r || (s2_r == s3_r))
        begin
          rd_nxt  = we_r ? rd_r : s3_r;
          cnt_nxt = 8'(`HOLD_CYC);
          st_nxt  = ES_HOLD;
        end
      end
      ES_HOLD:
      begin
        if (cnt_r <= 8'h01)
          st_nxt = ES_IDLE;
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      default:
        st_nxt = ES_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r   <= ES_IDLE;
      cnt_r  <= 8'h00;
      we_r   <= 1'b0;
      addr_r <= 20'h00000;
      dout_r <= 8'h00;
      rd_r   <= 8'h00;
    end
    else
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      we_r   <= we_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // pins come straight from state flops
  assign addr_o    = addr_r;
  assign dq_o      = dout_r;
  assign dq_oe     = we_r && (st_r != ES_IDLE);
  assign ce_n      = (st_r == ES_IDLE);
  assign we_n      = !(we_r && (st_r == ES_PULSE));
  assign oe_n      = !(!we_r && (st_r == ES_PULSE));
  assign cyc.ack   = (st_r == ES_HOLD) && (cnt_r <= 8'h01);
  assign cyc.rdata = rd_r;
endmodule

// ==== src/sector_protect_host.sv ====
// host controller for a boot-sector flash: command sequences, group protect,
// temporary unprotect and secure region handling, ordered over AXI4-Lite
// assumes an external switch lifts the flash reset pin to the elevated voltage on vid_en
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sgp_defs.svh"
module sector_protect_host (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite write channels
  input  wire logic [7:0]   s_awaddr,
  input  wire logic         s_awvalid,
  output logic              s_awready,
  input  wire logic [31:0]  s_wdata,
  input  wire logic [3:0]   s_wstrb,
  input  wire logic         s_wvalid,
  output logic              s_wready,
  output logic [1:0]        s_bresp,
  output logic              s_bvalid,
  input  wire logic         s_bready,
  // axi4-lite read channels
  input  wire logic [7:0]   s_araddr,
  input  wire logic         s_arvalid,
  output logic              s_arready,
  output logic [31:0]       s_rdata,
  output logic [1:0]        s_rresp,
  output logic              s_rvalid,
  input  wire logic         s_rready,
  // flash pins
  output logic [19:0]       flash_addr,
  input  wire logic [7:0]   flash_dq_i,
  output logic [7:0]        flash_dq_o,
  output logic              flash_dq_oe,
  output logic              flash_ce_n,
  output logic              flash_oe_n,
  output logic              flash_we_n,
  output logic              flash_reset_n,
  output logic              flash_wp_n,
  output logic              vid_en
);
  import sgp_pkg::*;

  flash_cycle_if cyc ();

  flash_cycle u_cycle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cyc     (cyc),
    .addr_o  (flash_addr),
    .dq_i    (flash_dq_i),
    .dq_o    (flash_dq_o),
    .dq_oe   (flash_dq_oe),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n)
  );

  ctl_state_t  st_r,    st_nxt;
  cmd_t        cmd_r,   cmd_nxt;
  logic [2:0]  idx_r,   idx_nxt;
  logic [19:0] addr_r,  addr_nxt;
  logic [7:0]  wd_r,    wd_nxt;
  logic [7:0]  rd_r,    rd_nxt;
  logic        done_r,  done_nxt;
  logic        err_r,   err_nxt;
  logic        sec_r,   sec_nxt;
  logic [3:0]  mode_r,  mode_nxt;
  logic [8:0]  prot_r,  prot_nxt;
  logic        awg_r,   awg_nxt;
  logic        wg_r,    wg_nxt;
  logic [7:0]  awa_r,   awa_nxt;
  logic [31:0] wdr_r,   wdr_nxt;
  logic        bv_r,    bv_nxt;
  logic [1:0]  br_r,    br_nxt;
  logic        rv_r,    rv_nxt;
  logic [1:0]  rr_r,    rr_nxt;
  logic [31:0] rdat_r,  rdat_nxt;
  step_t       cur;
  logic [3:0]  grp;

  // write cycle helper
  function automatic step_t wr(input logic [19:0] a, input logic [7:0] d, input logic l);
    wr = '{we: 1'b1, addr: a, data: d, last: l};
  endfunction

  // one step of each command sequence; never an unlock-bypass form
  function automatic step_t step_of(input cmd_t c, input logic [2:0] i, input logic [19:0] a,
                                    input logic [7:0] d);
    step_t s;
    s = wr(`SEQ_ADDR_1, `SEQ_DATA_1, 1'b0);
    case (i)
      3'h1:    s = wr(`SEQ_ADDR_2, `SEQ_DATA_2, 1'b0);
      3'h4:    s = wr(`SEQ_ADDR_1, `SEQ_DATA_1, 1'b0);
      3'h5:    s = wr(`SEQ_ADDR_2, `SEQ_DATA_2, 1'b0);
      3'h6:    s = wr(`SEQ_ADDR_1, `CMD_EXIT_BYTE, 1'b0);
      3'h7:    s = wr(`SEQ_ADDR_0, `CMD_EXIT2_BYTE, 1'b1);
      default: s = s;
    endcase
    case (c)
      CMD_READ:      s = '{we: 1'b0, addr: a, data: 8'h00, last: 1'b1};
      CMD_WRITE:     s = wr(a, d, 1'b1);
      CMD_RESET:     s = wr(`SEQ_ADDR_0, `CMD_RESET_BYTE, 1'b1);
      // A1 high, A0 low on the group address, A6 low to protect and high to unprotect; A7..A0 sit one bit up in byte mode
      CMD_PROTECT:   s = wr({a[19:9], `PROT_LOW, 1'b0}, `CMD_PROT_BYTE, 1'b1);
      CMD_UNPROTECT: s = wr({a[19:9], `UNPROT_LOW, 1'b0}, `CMD_PROT_BYTE, 1'b1);
      CMD_PROGRAM:
        if (i == 3'h2) s = wr(`SEQ_ADDR_1, `CMD_PROG_BYTE, 1'b0);
        else if (i == 3'h3) s = wr(a, d, 1'b1);
      CMD_SEC_ENTER:
        if (i == 3'h2) s = wr(`SEQ_ADDR_1, `CMD_ENTER_BYTE, 1'b1);
      CMD_SEC_EXIT:
        if (i == 3'h2) s = wr(`SEQ_ADDR_1, `CMD_EXIT_BYTE, 1'b0);
        else if (i == 3'h3) s = wr(`SEQ_ADDR_0, `CMD_EXIT2_BYTE, 1'b1);
      // entry, protect at the secure group address, then exit
      CMD_LOCK_SEC:
        if (i == 3'h2) s = wr(`SEQ_ADDR_1, `CMD_ENTER_BYTE, 1'b0);
        else if (i == 3'h3) s = wr({11'h000, `SEC_GROUP_LOW, 1'b0}, `CMD_PROT_BYTE, 1'b0);
      default:       s = wr(`SEQ_ADDR_0, `CMD_RESET_BYTE, 1'b1);
    endcase
    step_of = s;
  endfunction

  // sector group index from A18..A12 (byte address bits 19..13)
  function automatic logic [3:0] group_of(input logic [6:0] a, input logic top);
    logic [3:0] g;
    g = 4'h0;
    if (top)
    begin
      if (a[6:5] != 2'b11) g = {2'b00, a[6:5]};
      else if (!a[4]) g = 4'h3;
      else if (!a[3]) g = 4'h4;
      else if (!a[2]) g = 4'h5;
      else if (!a[1]) g = a[0] ? 4'h7 : 4'h6;
      else g = 4'h8;
    end
    else
    begin
      if (a[6:5] != 2'b00) g = 4'h5 + {2'b00, a[6:5]};
      else if (a[4]) g = 4'h5;
      else if (a[3]) g = 4'h4;
      else if (a[2]) g = 4'h3;
      else if (!a[1]) g = 4'h0;
      else g = a[0] ? 4'h2 : 4'h1;
    end
    group_of = g;
  endfunction

  assign cur       = step_of(cmd_r, idx_r, addr_r, wd_r);
  assign grp       = group_of(addr_r[19:13], mode_r[`MODE_TOP_BIT]);
  assign cyc.req   = (st_r == CS_RUN);
  assign cyc.we    = cur.we;
  assign cyc.addr  = cur.addr;
  assign cyc.wdata = cur.data;

  // bus handshakes: one write and one read at a time
  assign s_awready = !awg_r && !bv_r;
  assign s_wready  = !wg_r && !bv_r;
  assign s_arready = !rv_r;
  assign s_bvalid  = bv_r;
  assign s_bresp   = br_r;
  assign s_rvalid  = rv_r;
  assign s_rresp   = rr_r;
  assign s_rdata   = rdat_r;

  // flash control pins; the elevated voltage enters temporary unprotect
  assign vid_en        = mode_r[`MODE_VID_BIT];
  assign flash_wp_n    = mode_r[`MODE_WPN_BIT];
  assign flash_reset_n = mode_r[`MODE_RSTN_BIT];

  // register file, axi slave and sequencer
  always_comb
  begin
    logic       legal;
    logic [7:0] wa;
    logic [31:0] wd;
    wa     = 8'h00;
    wd     = 32'h00000000;
    legal  = 1'b0;
    st_nxt = st_r;   cmd_nxt = cmd_r;   idx_nxt = idx_r;   addr_nxt = addr_r;
    wd_nxt = wd_r;   rd_nxt = rd_r;     done_nxt = done_r; err_nxt = err_r;
    sec_nxt = sec_r; mode_nxt = mode_r; prot_nxt = prot_r;
    awg_nxt = awg_r; wg_nxt = wg_r;     awa_nxt = awa_r;   wdr_nxt = wdr_r;
    bv_nxt = bv_r;   br_nxt = br_r;     rv_nxt = rv_r;     rr_nxt = rr_r;
    rdat_nxt = rdat_r;
    if (s_awvalid && s_awready)
    begin
      awg_nxt = 1'b1;
      awa_nxt = s_awaddr;
    end
    if (s_wvalid && s_wready)
    begin
      wg_nxt  = 1'b1;
      wdr_nxt = s_wdata;
    end
    if (bv_r && s_bready)
      bv_nxt = 1'b0;
    wa = awa_nxt;
    wd = wdr_nxt;
    // register write once both address and data are held
    if (awg_nxt && wg_nxt && !bv_r)
    begin
      awg_nxt = 1'b0;
      wg_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = 2'b00;
      case (wa)
        `REG_CTRL:
          if (s_wstrb[1] && wd[`CTRL_START_BIT])
          begin
            case (wd[3:0])
              CMD_PROTECT:   legal = mode_r[`MODE_VID_BIT];
              CMD_LOCK_SEC:  legal = mode_r[`MODE_VID_BIT];
              CMD_UNPROTECT: legal = mode_r[`MODE_VID_BIT] && (&prot_r);
              CMD_PROGRAM:   legal = mode_r[`MODE_VID_BIT] || !prot_r[grp] || sec_r;
              default:       legal = (wd[3:0] <= 4'(CMD_RESET));
            endcase
            if (legal && st_r == CS_IDLE)
            begin
              cmd_nxt = cmd_t'(wd[3:0]);
              idx_nxt = 3'h0;
              st_nxt  = CS_RUN;
            end
            else
              err_nxt = 1'b1;
          end
        `REG_ADDR:   addr_nxt = wd[19:0];
        `REG_WDATA:  wd_nxt = wd[7:0];
        `REG_STATUS:
        begin
          if (wd[`ST_DONE_BIT]) done_nxt = 1'b0;
          if (wd[`ST_ERR_BIT]) err_nxt = 1'b0;
        end
        `REG_MODE:   mode_nxt = wd[3:0];
        `REG_PROT:   prot_nxt = wd[8:0];
        default:     br_nxt = 2'b10;
      endcase
    end
    // sequencer advance; completion set lands after any clear so set wins
    if (st_r == CS_RUN && cyc.ack)
    begin
      idx_nxt = idx_r + 3'h1;
      if (cur.last)
      begin
        st_nxt   = CS_IDLE;
        done_nxt = 1'b1;
        case (cmd_r)
          CMD_READ:      rd_nxt = cyc.rdata;
          CMD_SEC_ENTER: sec_nxt = 1'b1;
          CMD_SEC_EXIT:  sec_nxt = 1'b0;
          CMD_LOCK_SEC:  sec_nxt = 1'b0;
          CMD_PROTECT:   prot_nxt[grp] = 1'b1;
          CMD_UNPROTECT: prot_nxt = `PROT_RESET;
          default:       sec_nxt = sec_r;
        endcase
      end
    end
    // register read
    if (s_arvalid && s_arready)
    begin
      rv_nxt = 1'b1;
      rr_nxt = 2'b00;
      case (s_araddr)
        `REG_CTRL:   rdat_nxt = {28'h0000000, cmd_r};
        `REG_ADDR:   rdat_nxt = {12'h000, addr_r};
        `REG_WDATA:  rdat_nxt = {24'h000000, wd_r};
        // indicator is bit 7 of the last read byte
        `REG_STATUS: rdat_nxt = {7'h00, rd_r[7], 4'h0, grp, rd_r, 3'h0, sec_r, 1'b0,
                                 err_r, done_r, (st_r == CS_RUN)};
        `REG_MODE:   rdat_nxt = {28'h0000000, mode_r};
        `REG_PROT:   rdat_nxt = {23'h000000, prot_r};
        default:
        begin
          rdat_nxt = 32'h00000000;
          rr_nxt   = 2'b10;
        end
      endcase
    end
    else if (rv_r && s_rready)
      rv_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= CS_IDLE;     cmd_r <= CMD_READ;  idx_r <= 3'h0;   addr_r <= 20'h00000;
      wd_r <= 8'h00;       rd_r <= 8'h00;      done_r <= 1'b0;  err_r <= 1'b0;
      sec_r <= 1'b0;       mode_r <= `MODE_RESET;                prot_r <= `PROT_RESET;
      awg_r <= 1'b0;       wg_r <= 1'b0;       awa_r <= 8'h00;  wdr_r <= 32'h00000000;
      bv_r <= 1'b0;        br_r <= 2'b00;      rv_r <= 1'b0;    rr_r <= 2'b00;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      st_r <= st_nxt;      cmd_r <= cmd_nxt;   idx_r <= idx_nxt; addr_r <= addr_nxt;
      wd_r <= wd_nxt;      rd_r <= rd_nxt;     done_r <= done_nxt; err_r <= err_nxt;
      sec_r <= sec_nxt;    mode_r <= mode_nxt; prot_r <= prot_nxt;
      awg_r <= awg_nxt;    wg_r <= wg_nxt;     awa_r <= awa_nxt; wdr_r <= wdr_nxt;
      bv_r <= bv_nxt;      br_r <= br_nxt;     rv_r <= rv_nxt;   rr_r <= rr_nxt;
      rdat_r <= rdat_nxt;
    end
  end
endmodule

// ==== bench/sgp_properties.sv ====
// checker: flash bus cycle shape and register-bus answers of the protection host
// assumes binding to sector_protect_host, one clock, synchronous active-low reset
`timescale 1ns/1ps
module sgp_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_awvalid,
  input wire logic        s_awready,
  input wire logic        s_wvalid,
  input wire logic        s_wready,
  input wire logic        s_bvalid,
  input wire logic        s_arvalid,
  input wire logic        s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic        s_rvalid,
  input wire logic        s_rready,
  // flash pins
  input wire logic [19:0] flash_addr,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        vid_en
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // strobe shape: setup 2, low 5, hold 2, so slow parts still latch
  AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n[*5] ##1 flash_we_n)
    else $error("write strobe width wrong");
  AST_WE_SETUP: assert property ($fell(flash_we_n) |-> $past(flash_ce_n, 2) == 1'b0)
    else $error("write strobe without setup");
  AST_CE_HOLD: assert property ($rose(flash_we_n) |-> !flash_ce_n[*2] ##1 flash_ce_n)
    else $error("chip select hold wrong");
  AST_WE_DRIVE: assert property (!flash_we_n |-> flash_dq_oe && flash_oe_n)
    else $error("write strobe without driven data");
  AST_ADDR_STEADY: assert property (!flash_ce_n && $past(flash_ce_n) == 1'b0 |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  // register answers, idle state after reset and cover points
  AST_READ_ANSWER: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  AST_READ_STANDS: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read answer dropped");
  AST_WRITE_ANSWER: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> s_bvalid)
    else $error("write answer late");
  AST_RST_IDLE: assert property ($rose(aresetn) |-> flash_ce_n && !vid_en)
    else $error("bus or voltage active after reset");
  COV_WRITE: cover property ($fell(flash_we_n));
  COV_VID: cover property ($rose(vid_en));
  COV_READ: cover property (s_rvalid && s_rready);
endmodule

// ==== bench/flash_model.sv ====
// behavioural boot-sector flash, bottom-boot, byte mode: unlock cycles, group protect
// assumes pins from sector_protect_host; data pin resolved by the bench
`timescale 1ns/1ps
module flash_model #(
  parameter int TACC    = 30,
  parameter bit TOP     = 1'b0,
  parameter bit FACTORY = 1'b0
) (
  // bus pins
  input wire logic [19:0] addr,
  input wire logic [7:0]  dq_i,
  output logic [7:0]      dq_o,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  // control pins
  input wire logic        reset_n,
  input wire logic        wp_n,
  input wire logic        vid
);
  logic [7:0] mem [logic [19:0]];
  logic [7:0] sec [256];
  logic [8:0] prot = 9'h000; // shipped unprotected
  logic slock = FACTORY; // factory lock is final
  logic sm = 0;
  logic asel = 0;
  logic vld = 0;
  logic [7:0] q = 8'h00;
  int st = 0;
  int g;
  // group from A18..A12, small sectors at the bottom
  function automatic int grp(logic [6:0] a);
    if (a[6:5] != 2'h0) return 5 + a[6:5];
    if (a[4]) return 5;
    if (a[3]) return 4;
    if (a[2]) return 3;
    return a[1] ? 1 + a[0] : 0;
  endfunction
  // reads: codes in autoselect, region when mapped, else array
  function automatic logic [7:0] look();
    if (asel) return addr[8:1] == 8'h03 ? {FACTORY, 7'h16} : {7'h00, prot[g]};
    if (sm && addr[19:8] == {12{TOP}}) return sec[addr[7:0]];
    return mem.exists(addr) ? mem[addr] : 8'hff;
  endfunction
  always_comb g = grp(addr[19:13]);
  // serial number at the start of sector 0 in the separate region
  initial
  begin
    sec = '{default: 8'hff};
    sec[TOP ? 8'hf0 : 8'h00] = 8'h5a;
  end
  // temporary unprotect, two outer boot sectors kept while write-protect is low
  wire opn = vid && reset_n && !(!wp_n && g < 2);
  // command state on each write strobe release
  always @(posedge we_n)
  begin
    if (!ce_n && reset_n && vid && dq_i == 8'h60)
    begin
      if (sm && addr[8:1] == 8'h1a) slock = 1; // no way back once locked
      else if (addr[8:1] == 8'h02) prot[g] = 1;
      else if (addr[8:1] == 8'h42) prot = 9'h000;
      st = 0;
    end
    else if (!ce_n && reset_n)
    begin
      case (st)
        0: if (dq_i == 8'haa && addr == 20'h00aaa) st = 1;
           else if (dq_i == 8'hf0 || (asel && dq_i == 8'h00))
           begin
             sm = asel ? 1'b0 : sm;
             asel = 0;
           end
        1: st = dq_i == 8'h55 ? 2 : 0;
        2:
        begin
          st = dq_i == 8'ha0 ? 3 : 0; // no bypass command offered
          sm = sm || dq_i == 8'h88;
          asel = asel || dq_i == 8'h90;
        end
        default:
        begin
          st = 0;
          if (sm && addr[19:8] == {12{TOP}} && !slock) sec[addr[7:0]] = sec[addr[7:0]] & dq_i;
          else if (!sm && (!prot[g] || opn)) mem[addr] = look() & dq_i;
        end
      endcase
    end
  end
  // data valid after access time, inverse of it once released
  always @(negedge oe_n)
  begin
    vld = 0;
    #TACC q = look();
    vld = !oe_n;
  end
  always @(posedge oe_n) vld = 0;
  assign dq_o = vld ? q : ~q;
endmodule

// ==== bench/testbench.sv ====
// testbench: register-bus tasks driving protect, temporary unprotect and secure region
// assumes flash_model behind the pins, bottom-boot wiring
`timescale 1ns/1ps
`include "sgp_defs.svh"
module testbench;
  import sgp_pkg::*;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  s_awaddr = 8'h00, s_araddr = 8'h00;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rv, st;
  logic [3:0]  s_wstrb = 4'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, rr;
  logic [19:0] flash_addr;
  logic [7:0]  flash_dq_o, m_dq;
  logic        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, flash_wp_n, vid_en;
  wire  [7:0]  flash_dq_i = flash_dq_oe ? flash_dq_o : m_dq;
  int          failures = 0, cmp_count = 0, cyc = 0;
  logic [19:0] gb [9] = '{20'h00000, 20'h04000, 20'h06000, 20'h08000, 20'h10000, 20'h20000,
                          20'h40000, 20'h80000, 20'hc0000};
  sector_protect_host DUT (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
    .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
    .s_rresp, .s_rvalid, .s_rready, .flash_addr, .flash_dq_i, .flash_dq_o, .flash_dq_oe, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_wp_n, .vid_en);
  flash_model #(.TACC(25)) model (.addr(flash_addr), .dq_i(flash_dq_i), .dq_o(m_dq), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n), .wp_n(flash_wp_n), .vid(vid_en));
  initial forever #5 aclk = ~aclk;
  task automatic cmpv(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one write, each channel released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit pa = 1;
    bit pw = 1;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1;
    s_wvalid <= 1;
    s_bready <= 1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (s_awready) pa = 0;
      if (s_wready) pw = 0;
      s_awvalid <= pa;
      s_wvalid <= pw;
    end
    do @(posedge aclk); while (!s_bvalid);
    r = s_bresp;
    s_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1;
    s_rready <= 1;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 0;
    do @(posedge aclk); while (!s_rvalid);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 0;
  endtask
  // run one command, wait for done or error, compare the error flag
  task automatic go(input cmd_t c, input logic [19:0] a, input logic [7:0] d, input logic e);
    int n = 0;
    wr(`REG_STATUS, 32'h6, rr); // clear sticky flags first
    wr(`REG_ADDR, {12'h0, a}, rr);
    wr(`REG_WDATA, {24'h0, d}, rr);
    wr(`REG_CTRL, {23'h0, 1'b1, 4'h0, c}, rr);
    do
    begin
      rd(`REG_STATUS, st, rr);
      n++;
    end while ((st[0] || !(st[1] || st[2])) && n < 300);
    cmpv("status", {30'h0, 1'b1, e}, {30'h0, !st[0] && (st[1] || st[2]), st[2]});
  endtask
  task automatic rb(input logic [19:0] a, input logic [7:0] e);
    go(CMD_READ, a, 8'h00, 1'b0);
    cmpv("read byte", {24'h0, e}, {24'h0, st[15:8]});
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      failures++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    rd(`REG_MODE, rv, rr);
    cmpv("mode reset", 32'ha, rv);
    rd(`REG_PROT, rv, rr);
    cmpv("prot reset", 32'h0, rv);
    wr(8'h40, 32'h1, rr);
    cmpv("unmapped write", 32'h2, {30'h0, rr});
    rd(8'h44, rv, rr);
    cmpv("unmapped read", 32'h2, {30'h0, rr});
    go(CMD_PROGRAM, 20'h01000, 8'h3c, 1'b0);
    rb(20'h01000, 8'h3c);
    go(CMD_PROTECT, 20'h01000, 8'h00, 1'b1);
    wr(`REG_MODE, 32'hb, rr);
    go(CMD_PROTECT, 20'h01000, 8'h00, 1'b0);
    rd(`REG_PROT, rv, rr);
    cmpv("prot map", 32'h1, rv);
    wr(`REG_MODE, 32'ha, rr);
    go(CMD_PROGRAM, 20'h01000, 8'h00, 1'b1);
    rb(20'h01000, 8'h3c);
    wr(`REG_MODE, 32'hb, rr);
    go(CMD_PROGRAM, 20'h01000, 8'h0c, 1'b0);
    rb(20'h01000, 8'h0c);
    wr(`REG_MODE, 32'ha, rr);
    go(CMD_PROGRAM, 20'h01000, 8'h00, 1'b1);
    rb(20'h01000, 8'h0c);
    wr(`REG_MODE, 32'h9, rr); // write-protect low
    cmpv("pins", 32'h9, {28'h0, flash_reset_n, 1'b0, flash_wp_n, vid_en});
    go(CMD_PROGRAM, 20'h01000, 8'h00, 1'b0);
    rb(20'h01000, 8'h0c);
    wr(`REG_MODE, 32'hb, rr);
    rb(20'h00000, 8'hff);
    go(CMD_SEC_ENTER, 20'h0, 8'h00, 1'b0);
    cmpv("secure mode", 32'h1, {31'h0, st[4]});
    rb(20'h00000, 8'h5a);
    go(CMD_PROGRAM, 20'h00010, 8'h77, 1'b0);
    rb(20'h00010, 8'h77);
    go(CMD_LOCK_SEC, 20'h0, 8'h00, 1'b0);
    go(CMD_SEC_ENTER, 20'h0, 8'h00, 1'b0);
    go(CMD_PROGRAM, 20'h00010, 8'h00, 1'b0);
    rb(20'h00010, 8'h77);
    go(CMD_SEC_EXIT, 20'h0, 8'h00, 1'b0);
    rb(20'h01000, 8'h0c);
    go(CMD_WRITE, 20'h00aaa, 8'haa, 1'b0);
    go(CMD_WRITE, 20'h00555, 8'h55, 1'b0);
    go(CMD_WRITE, 20'h00aaa, 8'h90, 1'b0);
    rb(20'h00006, 8'h16);
    cmpv("indicator", 32'h0, {31'h0, st[24]});
    go(CMD_RESET, 20'h0, 8'h00, 1'b0);
    go(CMD_UNPROTECT, 20'h0, 8'h00, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      go(CMD_PROTECT, gb[i], 8'h00, 1'b0);
      cmpv("group", i, {28'h0, st[19:16]});
    end
    rd(`REG_PROT, rv, rr);
    cmpv("prot all", 32'h1ff, rv);
    go(CMD_UNPROTECT, 20'h0, 8'h00, 1'b0);
    rd(`REG_PROT, rv, rr);
    cmpv("prot cleared", 32'h0, rv);
    wr(`REG_MODE, 32'ha, rr);
    go(CMD_PROGRAM, 20'hc0000, 8'h11, 1'b0);
    rb(20'hc0000, 8'h11);
    go(cmd_t'(4'h9), 20'h0, 8'h00, 1'b1);
    wr(`REG_MODE, 32'he, rr);
    go(CMD_RESET, 20'hfc000, 8'h00, 1'b0);
    cmpv("top group", 32'h8, {28'h0, st[19:16]});
    give_verdict;
  end
endmodule
bind sector_protect_host sgp_properties chk (.aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
  .s_bvalid, .s_arvalid, .s_arready, .s_rdata, .s_rvalid, .s_rready, .flash_addr, .flash_dq_oe, .flash_ce_n,
  .flash_oe_n, .flash_we_n, .vid_en);
